// *** design/hbs_pkg.sv ***
// Package: constants and types for the programmable horizontal blanking start block
package hbs_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int HBS_CNT_W = 12;
	localparam int HBS_STEP_W = 4;
	localparam int HBS_DLY_W = 4;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int HBS_CLK_PERIOD_PS = 5000;
	// Fixed blanking delay after the zero crossing, least time
	localparam int HBS_DEFAULT_DELAY_PS = 10000;
	localparam int HBS_DLY_CYC_I = (HBS_DEFAULT_DELAY_PS + HBS_CLK_PERIOD_PS - 1) / HBS_CLK_PERIOD_PS;
	localparam logic [HBS_DLY_W-1:0] HBS_DLY_CYC =
		(HBS_DLY_CYC_I < 1) ? 4'h1 : HBS_DLY_W'(HBS_DLY_CYC_I);

	// ------------------------------------------------------------
	// Advance step: pixels per step, shift of the step count
	// ------------------------------------------------------------
	localparam int HBS_PIX_PER_STEP = 4;
	localparam int HBS_STEP_SHIFT = 2;

	// ------------------------------------------------------------
	// Constants at counter and delay widths
	// ------------------------------------------------------------
	localparam logic [HBS_CNT_W-1:0] HBS_CNT_ZERO = 12'h000;
	localparam logic [HBS_CNT_W-1:0] HBS_CNT_ONE = 12'h001;
	localparam logic [HBS_CNT_W-1:0] HBS_CNT_MAX = 12'hfff;
	localparam logic [HBS_DLY_W-1:0] HBS_DLY_ZERO = 4'h0;
	localparam logic [HBS_DLY_W-1:0] HBS_DLY_ONE = 4'h1;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		HBS_ST_SCAN = 2'b00,
		HBS_ST_DELAY = 2'b01,
		HBS_ST_BLANK = 2'b10
	} hbs_state_t;

	typedef struct packed {
		logic fly;
		logic [HBS_CNT_W-1:0] pix_cnt;
		logic [HBS_DLY_W-1:0] dly_cnt;
		hbs_state_t state;
		logic blank;
	} hbs_main_t;

	typedef struct packed {
		logic [HBS_CNT_W-1:0] line_len;
		logic valid;
	} hbs_meter_t;

endpackage

// *** design/hbs_line_meter.sv ***
// Line period meter: holds the pixel count between the last two retrace leading edges
`timescale 1ns/1ps
module hbs_line_meter
	import hbs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic line_start,
	input wire logic [HBS_CNT_W-1:0] cnt_in,
	output logic [HBS_CNT_W-1:0] line_len,
	output logic line_valid
);

	hbs_meter_t st_reg;
	hbs_meter_t st_next;

	// ------------------------------------------------------------
	// Capture
	// ------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		if (line_start)
		begin
			// Counter saturates, so a lost retrace never wraps into a short line
			st_next.line_len = (cnt_in == HBS_CNT_MAX) ? HBS_CNT_MAX : cnt_in + HBS_CNT_ONE;
			st_next.valid = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
		end
		else if (clk_en)
		begin
			st_reg <= st_next;
		end
	end

	assign line_len = st_reg.line_len;
	assign line_valid = st_reg.valid;

endmodule

// *** design/hbs_hblank_gen.sv ***
// Programmable horizontal blanking start generator, clocked by the OSD pixel clock
// Functional notes
// - Blanking start advances in steps of four pixels, at most sixteen steps.
// - Advance only moves blanking earlier than the retrace zero crossing, never later.
// - Blanking end follows the retrace trailing edge regardless of the advance.
// - Advance applies only when both blanking enable and programmable enable are set.
// - Step count comes from the four-bit step field.
`timescale 1ns/1ps
module hbs_hblank_gen
	import hbs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic retrace_in,
	input wire logic hblank_en,
	input wire logic prog_blank_en,
	input wire logic [HBS_STEP_W-1:0] blank_steps,
	output logic hblank_out
);

	hbs_main_t st_reg;
	hbs_main_t st_next;

	logic fly_rise;
	logic fly_fall;
	logic prog_on;
	logic [HBS_CNT_W:0] advance;
	logic [HBS_CNT_W:0] reach;
	logic early_hit;
	logic [HBS_CNT_W-1:0] line_len;
	logic line_valid;

	// ------------------------------------------------------------
	// Edge detect and advance
	// ------------------------------------------------------------
	assign fly_rise = retrace_in & ~st_reg.fly;
	assign fly_fall = ~retrace_in & st_reg.fly;
	assign prog_on = hblank_en & prog_blank_en;
	// Field value n gives n+1 steps of four pixels
	assign advance = (HBS_CNT_W+1)'({1'b0, blank_steps} + 5'h01) << HBS_STEP_SHIFT;
	assign reach = {1'b0, st_reg.pix_cnt} + advance + {1'b0, HBS_CNT_ONE};
	// Predicted zero crossing from the last line; early start only, never a delay
	assign early_hit = prog_on & line_valid & (advance < {1'b0, line_len}) & (reach >= {1'b0, line_len});

	hbs_line_meter u_meter (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.line_start(fly_rise),
		.cnt_in(st_reg.pix_cnt),
		.line_len(line_len),
		.line_valid(line_valid)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.fly = retrace_in;
		st_next.pix_cnt = fly_rise ? HBS_CNT_ZERO :
			((st_reg.pix_cnt == HBS_CNT_MAX) ? HBS_CNT_MAX : st_reg.pix_cnt + HBS_CNT_ONE);
		case (st_reg.state)
			HBS_ST_SCAN:
			begin
				if (fly_rise && prog_on)
				begin
					// Prediction missed: blank at the crossing itself, still no later
					st_next.state = HBS_ST_BLANK;
				end
				else if (fly_rise && hblank_en)
				begin
					st_next.state = HBS_ST_DELAY;
					st_next.dly_cnt = HBS_DLY_ONE;
				end
				else if (early_hit && !retrace_in)
				begin
					st_next.state = HBS_ST_BLANK;
				end
			end
			HBS_ST_DELAY:
			begin
				st_next.dly_cnt = st_reg.dly_cnt + HBS_DLY_ONE;
				if (fly_fall)
				begin
					st_next.state = HBS_ST_SCAN;
				end
				else if (st_reg.dly_cnt >= HBS_DLY_CYC)
				begin
					st_next.state = HBS_ST_BLANK;
				end
			end
			HBS_ST_BLANK:
			begin
				if (fly_fall)
				begin
					st_next.state = HBS_ST_SCAN;
				end
			end
			default:
			begin
				st_next.state = HBS_ST_SCAN;
			end
		endcase
		if (!hblank_en)
		begin
			st_next.state = HBS_ST_SCAN;
			st_next.dly_cnt = HBS_DLY_ZERO;
		end
		st_next.blank = (st_next.state == HBS_ST_BLANK);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
		end
		else if (clk_en)
		begin
			st_reg <= st_next;
		end
	end

	assign hblank_out = st_reg.blank;

endmodule

// *** tb/hbs_retrace_model.sv ***
// Horizontal retrace source model: fixed period, high during retrace
`timescale 1ns/1ps
module hbs_retrace_model
(
	input wire logic ref_clk,
	input wire logic run,
	input wire logic [11:0] period,
	input wire logic [11:0] width,
	output logic retrace = 1'b0
);
	logic [11:0] cnt = 12'h000;
	// Falling edge drive so the block samples a settled level
	always @(negedge ref_clk)
		if (!run)
		begin
			cnt <= 12'h000;
			retrace <= 1'b0;
		end
		else
		begin
			cnt <= (cnt == period - 12'h001) ? 12'h000 : cnt + 12'h001;
			retrace <= cnt < width;
		end
endmodule

// *** tb/hbs_hblank_gen_properties.sv ***
// Concurrent checks on the blanking start generator ports
`timescale 1ns/1ps
module hbs_gen_properties
	import hbs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic retrace_in,
	input wire logic hblank_en,
	input wire logic prog_blank_en,
	input wire logic [HBS_STEP_W-1:0] blank_steps,
	input wire logic hblank_out
);
	logic [6:0] early_cnt;
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			early_cnt <= 7'h00;
		else if (clk_en)
			early_cnt <= (hblank_out && !retrace_in) ? early_cnt + 7'h01 : 7'h00;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_off_forces_low: assert property (clk_en && !hblank_en |=> !hblank_out)
		else $error("blank while disabled");
	a_default_delay_start: assert property ($rose(retrace_in) && clk_en && hblank_en && !prog_blank_en
		##1 (clk_en && hblank_en && !prog_blank_en && retrace_in)[*2] |=> hblank_out)
		else $error("default start late");
	a_end_on_fall: assert property ($fell(retrace_in) && clk_en |=> !hblank_out)
		else $error("blank end moved");
	a_never_late: assert property ($rose(retrace_in) && clk_en && hblank_en && prog_blank_en |=> hblank_out)
		else $error("advanced start late");
	a_early_only_prog: assert property ($rose(hblank_out) && !retrace_in |-> $past(hblank_en && prog_blank_en))
		else $error("early start without enables");
	a_advance_max_bound: assert property (early_cnt <= 7'h44)
		else $error("advance too large");
	a_freeze_holds_out: assert property (!clk_en |=> $stable(hblank_out))
		else $error("output moved while frozen");
	a_steps_known_gap: assert property (clk_en && hblank_en && prog_blank_en && blank_steps == 4'hf && $fell(retrace_in)
		|=> !hblank_out)
		else $error("blank end moved at full advance");
	cover property ($rose(hblank_out) && !retrace_in);
	cover property ($rose(hblank_out) && retrace_in);
	cover property (early_cnt == 7'h3c);
endmodule
bind hbs_hblank_gen hbs_gen_properties hbs_gen_properties_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
	.retrace_in(retrace_in), .hblank_en(hblank_en), .prog_blank_en(prog_blank_en), .blank_steps(blank_steps),
	.hblank_out(hblank_out));

// *** tb/tb_programmable_hblank_start.sv ***
// Self-checking bench for the blanking start generator
`timescale 1ns/1ps
module tb_programmable_hblank_start
	import hbs_pkg::*;
;
	logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, hblank_en = 1'b0, prog_blank_en = 1'b0, run = 1'b0, rt_d = 1'b0;
	logic [HBS_STEP_W-1:0] blank_steps = 4'h0;
	logic retrace_in, hblank_out;
	int fail_count = 0, checked = 0, lead = 0, last_lead = 0, hi_cnt = 0;
	hbs_hblank_gen hbs_hblank_gen_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .retrace_in(retrace_in),
		.hblank_en(hblank_en), .prog_blank_en(prog_blank_en), .blank_steps(blank_steps), .hblank_out(hblank_out));
	hbs_retrace_model hbs_retrace_model_i (.ref_clk(ref_clk), .run(run), .period(12'h0c8), .width(12'h028),
		.retrace(retrace_in));
	initial forever #2.5 ref_clk = ~ref_clk;
	// Lead of blanking ahead of each retrace rise
	always @(posedge ref_clk)
	begin
		rt_d <= retrace_in;
		if (retrace_in && !rt_d)
			last_lead <= lead;
		lead <= (hblank_out && !retrace_in) ? lead + 1 : 0;
		hi_cnt <= hi_cnt + int'(hblank_out);
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// Two lines settle the period prediction, the third is measured
	task run_lines(input logic en, input logic prog, input logic [HBS_STEP_W-1:0] steps);
		@(negedge ref_clk);
		hblank_en = en;
		prog_blank_en = prog;
		blank_steps = steps;
		repeat (400) @(negedge ref_clk);
		hi_cnt = 0;
		repeat (200) @(negedge ref_clk);
	endtask
	task test_default;
		run_lines(1'b1, 1'b0, 4'h0);
		check(last_lead, 32'h0);
		check(hi_cnt != 0, 32'h1);
		$display("test_default done");
	endtask
	task test_steps;
		int a;
		for (int n = 0; n < 16; n++)
		begin
			a = (n + 1) * 4;
			run_lines(1'b1, 1'b1, 4'(n));
			check(last_lead + 2 >= a && last_lead <= a + 2, 32'h1);
		end
		$display("test_steps done");
	endtask
	// Clock enable low must freeze the blank output during the retrace
	task test_freeze;
		logic held;
		run_lines(1'b1, 1'b1, 4'h3);
		clk_en = 1'b0;
		held = hblank_out;
		repeat (50)
		begin
			@(negedge ref_clk);
			check(hblank_out, held);
		end
		clk_en = 1'b1;
		$display("test_freeze done");
	endtask
	task test_disabled;
		run_lines(1'b0, 1'b1, 4'hf);
		check(hi_cnt, 32'h0);
		run_lines(1'b1, 1'b0, 4'hf);
		check(last_lead, 32'h0);
		$display("test_disabled done");
	endtask
	task complete_run;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#200us;
		fail_count++;
		complete_run;
	end
	initial
	begin
		repeat (6) @(negedge ref_clk);
		rst_n = 1'b1;
		run = 1'b1;
		test_default;
		test_steps;
		test_freeze;
		test_disabled;
		complete_run;
	end
endmodule
